// File: debug_service_regs.sv
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
module debug_service_regs
  import dsvc_pkg::*;
(
  // clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // axi4-lite write address, data and response
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // system events (same clock)
  input  wire logic                 write_guard,
  input  wire logic                 device_protected,
  input  wire logic                 cold_plug_stretch,
  input  wire logic                 probe_detect,
  input  wire logic                 clock_pin_changed,
  input  wire logic                 mailbox0_write,
  input  wire logic                 mailbox1_write,
  input  wire logic                 mailbox0_read,
  input  wire logic                 mailbox1_read,
  // memory engine
  output dsvc_pkg::op_req_t         op_req,
  input  wire dsvc_pkg::op_rsp_t    op_rsp,
  output logic                      unit_reset
);

  // register state
  logic [4:0]  op_status_flags;
  logic        hotplug_allowed_flag;
  logic        mailbox0_dirty;
  logic        mailbox1_dirty;
  logic        probe_attached_flag;
  logic        locked_flag;
  logic        locked_caught;
  logic [31:0] op_start_address;
  logic [31:0] op_word_count;
  logic [31:0] op_data_word;
  logic        busy;

  // write channel capture
  logic [ADDR_W-1:0] aw_addr;
  logic              aw_held;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              w_held;
  logic              wr_fire;
  logic [12:0]       wr_idx;
  logic              wr_hit;
  logic [12:0]       rd_idx;
  logic              rd_hit;
  logic              soft_rst;
  logic [31:0]       wmask;

  assign wr_fire  = aw_held && w_held && !s_axi_bvalid;
  assign wr_idx   = aw_addr[ADDR_W-1:2];
  assign rd_idx   = s_axi_araddr[ADDR_W-1:2];
  assign soft_rst = wr_fire && wr_hit && (wr_idx == IDX_COMMAND)
                    && w_strb[0] && w_data[CMD_SOFT_RESET_TRIGGER_BIT];

  // per-lane write mask from strobes
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign wmask[8*g+7:8*g] = {8{w_strb[g]}};
    end
  endgenerate

  // address decode, guarded writes refused
  always_comb begin
    case (wr_idx)
      IDX_COMMAND, IDX_STATUS, IDX_DEBUG_STATE, IDX_START_ADDR,
      IDX_WORD_COUNT, IDX_DATA_WORD: wr_hit = !write_guard;
      default:                       wr_hit = 1'b0;
    endcase
  end

  always_comb begin
    case (rd_idx)
      IDX_COMMAND, IDX_STATUS, IDX_DEBUG_STATE, IDX_START_ADDR,
      IDX_WORD_COUNT, IDX_DATA_WORD, IDX_IDENT1, IDX_IDENT2,
      IDX_IDENT3: rd_hit = 1'b1;
      default:    rd_hit = 1'b0;
    endcase
  end

  // write address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      aw_addr       <= '0;
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_held       <= 1'b0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held       <= 1'b1;
      aw_addr       <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held       <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_held       <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held       <= 1'b1;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && !s_axi_bvalid;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // command decode: start pulses, forbidden commands while locked
  logic cmd_wr;
  logic any_start;
  assign cmd_wr    = wr_fire && wr_hit && (wr_idx == IDX_COMMAND)
                     && w_strb[0];
  assign any_start = cmd_wr && !soft_rst && !busy && (w_data[CMD_ERASE_BIT]
                     || w_data[CMD_SELFTEST_BIT] || w_data[CMD_CRC_BIT]);

  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      op_req.start <= 1'b0;
      op_req.kind  <= OP_ERASE;
      busy         <= 1'b0;
    end else begin
      op_req.start <= 1'b0;
      if (any_start) begin
        if (w_data[CMD_ERASE_BIT]) begin
          op_req.start <= 1'b1;
          op_req.kind  <= OP_ERASE;
          busy         <= 1'b1;
        end else if (!locked_flag) begin
          op_req.start <= 1'b1;
          busy         <= 1'b1;
          op_req.kind  <= w_data[CMD_SELFTEST_BIT] ? OP_SELFTEST
                                                    : OP_CRC;
        end
      end else if (op_rsp.done) begin
        busy <= 1'b0;
      end
    end
  end

  // operands pass to the engine through one register stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_req.addr  <= WORD_RESET;
      op_req.count <= WORD_RESET;
      op_req.seed  <= WORD_RESET;
    end else begin
      op_req.addr  <= op_start_address;
      op_req.count <= op_word_count;
      op_req.seed  <= op_data_word;
    end
  end

  // unit reset pulse out
  always_ff @(posedge aclk) begin
    if (!aresetn) unit_reset <= 1'b0;
    else          unit_reset <= soft_rst;
  end

  // status flags: set wins over write-one clear
  logic [4:0] flag_set;
  logic [4:0] flag_clr;
  assign flag_set[ST_LOCKED_FLAG_ERR_BIT] = any_start && locked_flag
                                     && !w_data[CMD_ERASE_BIT];
  assign flag_set[ST_FAIL_BIT]     = busy && op_rsp.fail;
  assign flag_set[ST_BUS_ERR_BIT]  = busy && op_rsp.bus_err;
  assign flag_set[ST_STRETCH_BIT]  = cold_plug_stretch;
  assign flag_set[ST_DONE_BIT]     = busy && op_rsp.done;
  assign flag_clr = (wr_fire && wr_hit && wr_idx == IDX_STATUS
                     && w_strb[0]) ? w_data[4:0] : 5'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) op_status_flags <= STATUS_RESET;
    else op_status_flags <= (op_status_flags & ~flag_clr) | flag_set;
  end

  // debug state bits, read-only from the bus
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hotplug_allowed_flag <= 1'b1;
      mailbox0_dirty       <= 1'b0;
      mailbox1_dirty       <= 1'b0;
      probe_attached_flag  <= 1'b0;
      locked_flag          <= 1'b0;
      locked_caught        <= 1'b0;
    end else begin
      if (clock_pin_changed) hotplug_allowed_flag <= 1'b0;
      if (mailbox0_write)     mailbox0_dirty <= 1'b1;
      else if (mailbox0_read) mailbox0_dirty <= 1'b0;
      if (mailbox1_write)     mailbox1_dirty <= 1'b1;
      else if (mailbox1_read) mailbox1_dirty <= 1'b0;
      if (probe_detect) probe_attached_flag <= 1'b1;
      if (!locked_caught) begin
        locked_caught <= 1'b1;
        locked_flag   <= device_protected;
      end
    end
  end

  // parameter registers with lane writes
  logic wr_addr_reg;
  logic wr_cnt_reg;
  logic wr_data_reg;
  assign wr_addr_reg = wr_fire && wr_hit && wr_idx == IDX_START_ADDR;
  assign wr_cnt_reg  = wr_fire && wr_hit && wr_idx == IDX_WORD_COUNT;
  assign wr_data_reg = wr_fire && wr_hit && wr_idx == IDX_DATA_WORD;

  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      op_start_address <= WORD_RESET;
      op_word_count    <= WORD_RESET;
      op_data_word     <= WORD_RESET;
    end else begin
      if (wr_addr_reg)
        op_start_address <= ((op_start_address & ~wmask)
                             | (w_data & wmask)) & LOW2_MASK;
      if (wr_cnt_reg)
        op_word_count <= ((op_word_count & ~wmask)
                          | (w_data & wmask)) & LOW2_MASK;
      if (busy && op_rsp.done)
        op_data_word <= op_rsp.result;
      else if (wr_data_reg)
        op_data_word <= (op_data_word & ~wmask) | (w_data & wmask);
    end
  end

  // read mux, reserved bits zero
  logic [31:0] next_rdata;
  always_comb begin
    case (rd_idx)
      IDX_COMMAND:     next_rdata = 32'h0000_0000; // write-only bits
      IDX_STATUS:      next_rdata = {27'h0, op_status_flags};
      IDX_DEBUG_STATE: next_rdata = {27'h0, hotplug_allowed_flag,
                                     mailbox1_dirty, mailbox0_dirty,
                                     probe_attached_flag, locked_flag};
      IDX_START_ADDR:  next_rdata = op_start_address;
      IDX_WORD_COUNT:  next_rdata = op_word_count;
      IDX_DATA_WORD:   next_rdata = op_data_word;
      IDX_IDENT1:      next_rdata = IDENT1_VALUE;
      IDX_IDENT2:      next_rdata = IDENT2_VALUE;
      IDX_IDENT3:      next_rdata = IDENT3_VALUE;
      default:         next_rdata = 32'h0000_0000;
    endcase
  end

  // read channel: one cycle after address taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // assertions
  a_start_on_erase: assert property (@(posedge aclk) disable iff (!aresetn)
    any_start && w_data[CMD_ERASE_BIT] |=> op_req.start)
    else $error("erase command did not start");
  a_locked_refuse: assert property (@(posedge aclk) disable iff (!aresetn)
    any_start && locked_flag && !w_data[CMD_ERASE_BIT]
    |=> !op_req.start && op_status_flags[ST_LOCKED_FLAG_ERR_BIT])
    else $error("locked command not refused");
  a_done_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    busy && op_rsp.done && !soft_rst |=> op_status_flags[ST_DONE_BIT])
    else $error("done flag not set");
  a_clear_one: assert property (@(posedge aclk) disable iff (!aresetn)
    flag_clr[ST_FAIL_BIT] && !flag_set[ST_FAIL_BIT]
    |=> !op_status_flags[ST_FAIL_BIT])
    else $error("fail flag not cleared");
  a_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    flag_set[ST_BUS_ERR_BIT] && !soft_rst
    |=> op_status_flags[ST_BUS_ERR_BIT])
    else $error("bus error flag lost");
  a_probe_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    probe_attached_flag |=> probe_attached_flag)
    else $error("probe flag cleared");
  a_hotplug_off: assert property (@(posedge aclk) disable iff (!aresetn)
    clock_pin_changed |=> !hotplug_allowed_flag [*3])
    else $error("hot-plug bit returned");
  a_addr_low_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    op_start_address[1:0] == 2'b00 && op_word_count[1:0] == 2'b00)
    else $error("low address bits nonzero");
  a_mbox_dirty: assert property (@(posedge aclk) disable iff (!aresetn)
    mailbox0_write |=> mailbox0_dirty)
    else $error("mailbox dirty not set");
  a_guard_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && write_guard |=> $stable(op_data_word) || $past(busy))
    else $error("guarded write took effect");
  a_soft_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    soft_rst |=> op_status_flags == STATUS_RESET && unit_reset)
    else $error("soft reset incomplete");

  c_write_resp: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
  c_read_resp:  cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
  c_op_done:    cover property (@(posedge aclk) busy && op_rsp.done);
  c_locked_flag_err:   cover property (@(posedge aclk) flag_set[ST_LOCKED_FLAG_ERR_BIT]);

endmodule // debug_service_regs

// File: dsvc_pkg.sv
package dsvc_pkg;

  // register word indices (printed offsets include 0x1 and 0x2, so word
  // index * 4 is the bus byte address)
  localparam logic [12:0] IDX_COMMAND     = 13'h0000;
  localparam logic [12:0] IDX_STATUS      = 13'h0001;
  localparam logic [12:0] IDX_DEBUG_STATE = 13'h0002;
  localparam logic [12:0] IDX_START_ADDR  = 13'h0004;
  localparam logic [12:0] IDX_WORD_COUNT  = 13'h0008;
  localparam logic [12:0] IDX_DATA_WORD   = 13'h000C;
  localparam logic [12:0] IDX_IDENT1      = 13'h1FF4;
  localparam logic [12:0] IDX_IDENT2      = 13'h1FF8;
  localparam logic [12:0] IDX_IDENT3      = 13'h1FFC;

  // byte offset of index i is i*4; word address bits [14:2] hold the index
  localparam int ADDR_W = 15;

  // command register bits
  localparam int CMD_ERASE_BIT   = 4;
  localparam int CMD_SELFTEST_BIT = 3;
  localparam int CMD_CRC_BIT     = 2;
  localparam int CMD_SOFT_RESET_TRIGGER_BIT   = 0;

  // status flag bits
  localparam int ST_LOCKED_FLAG_ERR_BIT = 4;
  localparam int ST_FAIL_BIT     = 3;
  localparam int ST_BUS_ERR_BIT  = 2;
  localparam int ST_STRETCH_BIT  = 1;
  localparam int ST_DONE_BIT     = 0;
  localparam logic [4:0] STATUS_RESET = 5'h00;

  // debug state bits
  localparam int DS_HOTPLUG_BIT = 4;
  localparam int DS_MBOX1_BIT   = 3;
  localparam int DS_MBOX0_BIT   = 2;
  localparam int DS_PROBE_BIT   = 1;
  localparam int DS_LOCKED_BIT  = 0;

  localparam logic [31:0] WORD_RESET   = 32'h0000_0000;
  localparam logic [31:0] LOW2_MASK    = 32'hFFFF_FFFC;

  // identification words; values arbitrary
  localparam logic [31:0] IDENT1_VALUE = 32'h0000_0010;
  localparam logic [31:0] IDENT2_VALUE = 32'h0000_0005;
  localparam logic [31:0] IDENT3_VALUE = 32'h0000_00B1;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // operation kinds
  typedef enum logic [2:0] {
    OP_ERASE    = 3'b001,
    OP_SELFTEST = 3'b010,
    OP_CRC      = 3'b100
  } op_kind_t;

  // start request to the memory engine
  typedef struct packed {
    logic        start;
    op_kind_t    kind;
    logic [31:0] addr;
    logic [31:0] count;
    logic [31:0] seed;
  } op_req_t;

  // report back from the memory engine
  typedef struct packed {
    logic        done;
    logic        fail;
    logic        bus_err;
    logic [31:0] result;
  } op_rsp_t;

endpackage

// File: engine_model.sv
`timescale 1ns/1ps
module engine_model
  import dsvc_pkg::*;
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // scenario controls
  input  wire logic              slow,
  input  wire logic              fail_mode,
  input  wire logic              bus_fault_flag_mode,
  // request in, report out
  input  wire dsvc_pkg::op_req_t op_req,
  output dsvc_pkg::op_rsp_t      op_rsp
);
  logic [5:0]  wait_cnt;
  logic [31:0] seed_q;

  // count down after a start, then report the inverted seed for one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_cnt <= 6'h00;
      seed_q   <= 32'h0000_0000;
      op_rsp   <= '0;
    end else begin
      op_rsp.done    <= 1'b0;
      op_rsp.fail    <= 1'b0;
      op_rsp.bus_err <= 1'b0;
      op_rsp.result  <= ~op_rsp.result; // idle lines keep toggling
      if (op_req.start) begin
        wait_cnt <= slow ? 6'h14 : 6'h02;
        seed_q   <= op_req.seed;
      end else if (wait_cnt != 6'h00) begin
        wait_cnt <= wait_cnt - 6'h01;
        if (wait_cnt == 6'h01) begin
          op_rsp <= {1'b1, fail_mode, bus_fault_flag_mode, ~seed_q};
        end
      end
    end
  end
endmodule // engine_model

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
  import dsvc_pkg::*;
  typedef struct {
    logic wr; logic [14:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] e;
  } row_t;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [14:0] awaddr = '0, araddr = '0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0]  wstrb = '0;
  logic        awready, wready, bvalid, arready, rvalid, unit_reset;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, got, seed;
  logic [8:0]  ev = '0;
  logic        slow = 1'b0, fail_mode = 1'b0, bus_fault_flag_mode = 1'b0;
  op_req_t     op_req;
  op_rsp_t     op_rsp;
  op_kind_t    last_kind;
  int          err_total = 0, cmp_count = 0, starts = 0, resets = 0;
  int          cycles = 0, s0, r0;
  row_t rows [0:16] = '{
    '{0, 15'h0004, 32'h0, 4'h0, 32'h0000_0000},
    '{0, 15'h0008, 32'h0, 4'h0, 32'h0000_0010},
    '{0, 15'h0010, 32'h0, 4'h0, 32'h0000_0000},
    '{0, 15'h0020, 32'h0, 4'h0, 32'h0000_0000},
    '{0, 15'h0030, 32'h0, 4'h0, 32'h0000_0000},
    '{0, 15'h0000, 32'h0, 4'h0, 32'h0000_0000},
    '{1, 15'h0010, 32'hFFFF_FFFF, 4'hF, 32'hFFFF_FFFC},
    '{1, 15'h0020, 32'h1234_5677, 4'hF, 32'h1234_5674},
    '{1, 15'h0020, 32'h0000_00AB, 4'h1, 32'h1234_56A8},
    '{1, 15'h0030, 32'h1111_1111, 4'hF, 32'h1111_1111},
    '{1, 15'h0030, 32'hAABB_CCDD, 4'h4, 32'h11BB_1111},
    '{1, 15'h0030, 32'hAABB_CCDD, 4'h9, 32'hAABB_11DD},
    '{1, 15'h0008, 32'hFFFF_FFFF, 4'hF, 32'h0000_0010},
    '{1, 15'h7FD0, 32'hFFFF_FFFF, 4'hF, IDENT1_VALUE},
    '{1, 15'h7FE0, 32'hFFFF_FFFF, 4'hF, IDENT2_VALUE},
    '{1, 15'h7FF0, 32'hFFFF_FFFF, 4'hF, IDENT3_VALUE},
    '{1, 15'h0004, 32'h0000_00FF, 4'hF, 32'h0000_0000}};

  debug_service_regs dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cold_plug_stretch(ev[0]), .probe_detect(ev[1]),
    .clock_pin_changed(ev[2]), .mailbox0_write(ev[3]),
    .mailbox1_write(ev[4]), .mailbox0_read(ev[5]), .mailbox1_read(ev[6]),
    .write_guard(ev[7]), .device_protected(ev[8]),
    .op_req(op_req), .op_rsp(op_rsp), .unit_reset(unit_reset));

  engine_model engine_u (.aclk(aclk), .aresetn(aresetn), .slow(slow),
    .fail_mode(fail_mode), .bus_fault_flag_mode(bus_fault_flag_mode), .op_req(op_req),
    .op_rsp(op_rsp));

  // clock, starts, unit resets and the hang limit
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (op_req.start === 1'b1) begin
      starts++;
      last_kind = op_req.kind;
    end
    if (unit_reset === 1'b1) resets++;
    if (cycles == 20000) begin
      err_total++;
      conclude();
    end
  end

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    chk_word({30'h0, g}, {30'h0, e});
  endtask

  // one write; both channels offered together, held until taken
  task automatic wr(input logic [14:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 200);
    if (n >= 200) err_total++;
    resp = bresp;
    bready <= 1'b0;
  endtask

  // one read, address held until taken
  task automatic rd(input logic [14:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 200);
    if (n >= 200) err_total++;
    got = rdata; resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic pulse(input int b);
    @(posedge aclk);
    ev[b] <= 1'b1;
    @(posedge aclk);
    ev[b] <= 1'b0;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    do begin
      rd(15'h0004);
      n++;
    end while (got[0] !== 1'b1 && n < 40);
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    // table of reset values and plain register accesses
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d, rows[i].s);
      rd(rows[i].a);
      chk_word(got, rows[i].e);
    end
    // operands mirrored to the engine
    chk_word(op_req.addr, 32'hFFFF_FFFC);
    chk_word(op_req.count, 32'h1234_56A8);
    // each of the erase, selftest and CRC command bits starts its kind; result lands in the data word
    seed = 32'hAABB_11DD;
    for (int b = 4; b >= 2; b--) begin
      s0 = starts;
      wr(15'h0000, 32'h1 << b, 4'h1);
      wait_done();
      chk_word(got, 32'h0000_0001);
      chk_word({29'h0, last_kind}, {29'h0, 3'b001 << (4 - b)});
      chk_word(starts - s0, 1);
      rd(15'h0030);
      chk_word(got, ~seed);
      seed = ~seed;
      wr(15'h0004, 32'h0000_0001, 4'h1);
      rd(15'h0004);
      chk_word(got, 32'h0000_0000);
    end
    // slow operation reporting failure and bus fault
    slow <= 1'b1; fail_mode <= 1'b1; bus_fault_flag_mode <= 1'b1;
    wr(15'h0000, 32'h0000_0004, 4'h1);
    wait_done();
    chk_word(got, 32'h0000_000D);
    wr(15'h0004, 32'h0000_000C, 4'h1);
    rd(15'h0004);
    chk_word(got, 32'h0000_0001);
    wr(15'h0004, 32'h0000_0001, 4'h1);
    // unmapped place and guarded write
    rd(15'h000C);
    chk_resp(resp, RESP_SLVERR);
    chk_word(got, 32'h0000_0000);
    wr(15'h000C, 32'h0000_0001, 4'hF);
    chk_resp(resp, RESP_SLVERR);
    ev[7] <= 1'b1;
    wr(15'h0010, 32'h0000_0100, 4'hF);
    chk_resp(resp, RESP_SLVERR);
    ev[7] <= 1'b0;
    rd(15'h0010);
    chk_word(got, 32'hFFFF_FFFC);
    // system events into status and debug state
    pulse(0);
    rd(15'h0004);
    chk_word(got, 32'h0000_0002);
    pulse(1);
    pulse(3);
    pulse(4);
    rd(15'h0008);
    chk_word(got, 32'h0000_001E);
    pulse(5);
    rd(15'h0008);
    chk_word(got, 32'h0000_001A);
    pulse(2);
    rd(15'h0008);
    chk_word(got, 32'h0000_000A);
    // software reset
    r0 = resets;
    wr(15'h0000, 32'h0000_0001, 4'h1);
    repeat (3) @(posedge aclk);
    chk_word(resets - r0, 1);
    rd(15'h0010);
    chk_word(got, 32'h0000_0000);
    rd(15'h0004);
    chk_word(got, 32'h0000_0000);
    // locked device after a second reset
    @(posedge aclk);
    ev[8] <= 1'b1;
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(15'h0008);
    chk_word(got, 32'h0000_0011);
    s0 = starts;
    wr(15'h0000, 32'h0000_0008, 4'h1);
    repeat (4) @(posedge aclk);
    rd(15'h0004);
    chk_word(got, 32'h0000_0010);
    chk_word(starts - s0, 0);
    conclude();
  end
endmodule // testbench
